// File: scc_pkg.sv
// Shared constants and types for the serial channel command decoder
package scc_pkg;

  localparam int NUM_CH = 2;
  localparam int NUM_WREG = 8;
  localparam int BYTE_W = 8;
  localparam int PTR_W = 3;
  localparam int CRC_W = 16;

  // Select input encodings
  localparam logic SEL_CHAN_A = 1'b0;
  localparam logic SEL_CHAN_B = 1'b1;
  localparam logic SEL_DATA = 1'b0;
  localparam logic SEL_CMD = 1'b1;

  // Command byte layout
  localparam int PTR_LSB = 0;
  localparam int CMD_LSB = 3;
  localparam int CRC_LSB = 6;

  typedef enum logic [2:0] {
    CMD_NULL,
    CMD_SEND_ABORT,
    CMD_RST_EXT,
    CMD_CHAN_RST,
    CMD_RX_REARM,
    CMD_RST_TXINT,
    CMD_ERR_RST,
    CMD_RETURN_FROM_INTERRUPT_OPCODE
  } scc_cmd_e;

  typedef enum logic [1:0] {
    CRC_NULL,
    CRC_RST_RX,
    CRC_RST_TX,
    CRC_RST_EOM
  } scc_crc_e;

  // Register pointer values
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_IRQ_CFG = 3'h1;
  localparam logic [2:0] REG_VECTOR = 3'h2;
  localparam logic [2:0] REG_MODE = 3'h4;
  localparam logic [2:0] RD_PRIMARY = 3'h0;
  localparam logic [2:0] RD_SPECIAL = 3'h1;
  localparam logic [2:0] RD_VECTOR = 3'h2;

  // Interrupt configuration register fields
  localparam int IRQ_EXT_EN_BIT = 0;
  localparam int IRQ_TX_EN_BIT = 1;
  localparam int IRQ_RXM_LSB = 3;
  localparam logic [1:0] RXM_OFF = 2'h0;
  localparam logic [1:0] RXM_FIRST = 2'h1;

  // Mode register sync-mode field
  localparam int MODE_SYNC_LSB = 4;
  localparam logic [1:0] MODE_SDLC = 2'h2;

  // Special receive status bits
  localparam int RR1_PAR_BIT = 4;
  localparam int RR1_OVR_BIT = 5;

  localparam logic [CRC_W-1:0] CRC_ZEROS = 16'h0000;
  localparam logic [CRC_W-1:0] CRC_ONES = 16'hFFFF;

  // Host-side Avalon register map
  localparam logic [3:0] AV_CMD = 4'h0;
  localparam logic [3:0] AV_STAT = 4'h4;
  localparam int AV_CTL_BIT = 8;
  localparam int AV_CHAN_BIT = 9;
  localparam int AV_READ_BIT = 10;
  localparam int AV_BUSY_BIT = 0;
  localparam int AV_RDATA_LSB = 8;

  // Quiet time after a channel reset, in system clock cycles
  localparam int RESET_GAP_CLK = 4;
  localparam logic [2:0] RESET_GAP_CYC = 3'(RESET_GAP_CLK);
  localparam logic [2:0] GAP_LAST = 3'h1;

endpackage

// File: scc_if.sv
// Parallel host bus between the CPU-side end and the channel decoder
interface scc_if;
  logic wr_stb;
  logic rd_stb;
  logic chan_sel;
  logic ctl_sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;

  modport host (
    output wr_stb, rd_stb, chan_sel, ctl_sel, wdata,
    input rdata, rvalid
  );

  modport dev (
    input wr_stb, rd_stb, chan_sel, ctl_sel, wdata,
    output rdata, rvalid
  );
endinterface

// File: scc_dev.sv
// Two-channel command port decoder: pointers, write registers, commands
// Overview of operation
// - Control/data and channel selects pick port
// - Eight independent write registers per channel
// - Non-command registers take pointer then value
// - Hardware or channel reset clears pointer to command
// - Pointer returns to command after access
// - Pointer selects next write or read register
// - Command byte: CRC code, command, pointer
// - Command zero does nothing
// - Send abort only in SDLC mode
// - External status latched until command two
// - Command three resets channel, A also priority
// - Host waits four cycles after channel reset
// - Command four rearms first-character interrupt
// - Command five clears and suppresses transmit interrupt
// - Command six clears parity and overrun latches
// - Command seven on A acts as return
// - CRC code selects receive, transmit, underrun reset
// - CRC presets zeros, ones in SDLC mode
// - Host writes mode register first
// - Commands decoded from every pointer byte
//
// Local design decisions: the register addresses and register access over Avalon-MM.
module scc_dev
  import scc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  scc_if.dev bus,
  input wire logic [1:0] ext_change_i,
  input wire logic [1:0][7:0] ext_status_i,
  input wire logic [1:0] rx_char_i,
  input wire logic [1:0][7:0] rx_data_i,
  input wire logic [1:0] parity_err_i,
  input wire logic [1:0] overrun_err_i,
  input wire logic [1:0] tx_empty_i,
  input wire logic [1:0] tx_load_i,
  input wire logic [1:0] crc_done_i,
  input wire logic [1:0] underrun_i,
  output logic [1:0][7:0][7:0] wreg_o,
  output logic [1:0] ext_int_o,
  output logic [1:0] rx_int_o,
  output logic [1:0] tx_int_o,
  output logic [1:0] eom_latch_o,
  output logic [1:0] send_abort_o,
  output logic [1:0] chan_rst_o,
  output logic [1:0] rx_crc_rst_o,
  output logic [1:0] tx_crc_rst_o,
  output logic [1:0][15:0] rx_crc_seed_o,
  output logic [1:0][15:0] tx_crc_seed_o,
  output logic prio_rst_o,
  output logic return_from_interrupt_opcode_o,
  output logic [7:0] tx_data_o,
  output logic [1:0] tx_data_vld_o
);

  typedef struct packed {
    logic [1:0][2:0] ptr;
    logic [1:0][7:0][7:0] wreg;
    logic [1:0] ext_hold;
    logic [1:0][7:0] rr0_snap;
    logic [1:0] par_err;
    logic [1:0] ovr_err;
    logic [1:0] tx_supp;
    logic [1:0] rx_arm;
    logic [1:0] ext_int;
    logic [1:0] rx_int;
    logic [1:0] tx_int;
    logic [1:0] end_of_message;
    logic [1:0] abort;
    logic [1:0] crst;
    logic [1:0] rxcrc;
    logic [1:0] txcrc;
    logic [1:0][15:0] rxseed;
    logic [1:0][15:0] txseed;
    logic prio;
    logic return_from_interrupt_opcode;
    logic [7:0] txd;
    logic [1:0] txv;
    logic [7:0] rdata;
    logic rvalid;
  } scc_dev_s;

  scc_dev_s st_ff;
  scc_dev_s nxt_st;

  always_comb
  begin
    logic ch;
    logic [7:0] b;
    logic [7:0] cfg;
    logic sdlc;
    logic [7:0] rr1;
    ch = bus.chan_sel;
    b = bus.wdata;
    cfg = 8'h00;
    sdlc = 1'b0;
    rr1 = 8'h00;
    nxt_st = st_ff;
    nxt_st.abort = '0;
    nxt_st.crst = '0;
    nxt_st.rxcrc = '0;
    nxt_st.txcrc = '0;
    nxt_st.prio = 1'b0;
    nxt_st.return_from_interrupt_opcode = 1'b0;
    nxt_st.txv = '0;
    nxt_st.rvalid = 1'b0;
    sdlc = (st_ff.wreg[ch][REG_MODE][MODE_SYNC_LSB +: 2] == MODE_SDLC);

    if (bus.wr_stb && (bus.ctl_sel == SEL_DATA))
    begin
      nxt_st.txd = b;
      nxt_st.txv[ch] = 1'b1;
    end
    else if (bus.wr_stb && (st_ff.ptr[ch] != REG_CMD))
    begin
      nxt_st.wreg[ch][st_ff.ptr[ch]] = b;
      nxt_st.ptr[ch] = REG_CMD;
    end
    else if (bus.wr_stb)
    begin
      nxt_st.wreg[ch][REG_CMD] = b;
      nxt_st.ptr[ch] = b[PTR_LSB +: PTR_W];
      case (scc_cmd_e'(b[CMD_LSB +: 3]))
        CMD_NULL: ;
        CMD_SEND_ABORT:
        begin
          nxt_st.abort[ch] = sdlc;
        end
        CMD_RST_EXT:
        begin
          nxt_st.ext_hold[ch] = 1'b0;
          nxt_st.ext_int[ch] = 1'b0;
        end
        CMD_CHAN_RST:
        begin
          nxt_st.wreg[ch] = '0;
          nxt_st.ptr[ch] = REG_CMD;
          nxt_st.ext_hold[ch] = 1'b0;
          nxt_st.rr0_snap[ch] = 8'h00;
          nxt_st.par_err[ch] = 1'b0;
          nxt_st.ovr_err[ch] = 1'b0;
          nxt_st.tx_supp[ch] = 1'b0;
          nxt_st.rx_arm[ch] = 1'b1;
          nxt_st.ext_int[ch] = 1'b0;
          nxt_st.rx_int[ch] = 1'b0;
          nxt_st.tx_int[ch] = 1'b0;
          nxt_st.end_of_message[ch] = 1'b0;
          nxt_st.rxseed[ch] = CRC_ZEROS;
          nxt_st.txseed[ch] = CRC_ZEROS;
          nxt_st.crst[ch] = 1'b1;
          nxt_st.prio = (ch == SEL_CHAN_A);
        end
        CMD_RX_REARM:
        begin
          if (st_ff.wreg[ch][REG_IRQ_CFG][IRQ_RXM_LSB +: 2] == RXM_FIRST)
          begin
            nxt_st.rx_arm[ch] = 1'b1;
          end
        end
        CMD_RST_TXINT:
        begin
          nxt_st.tx_int[ch] = 1'b0;
          nxt_st.tx_supp[ch] = 1'b1;
        end
        CMD_ERR_RST:
        begin
          nxt_st.par_err[ch] = 1'b0;
          nxt_st.ovr_err[ch] = 1'b0;
        end
        default:
        begin
          nxt_st.return_from_interrupt_opcode = (ch == SEL_CHAN_A);
        end
      endcase
      // A channel reset owns the byte; CRC code is not applied on top of it
      if (scc_cmd_e'(b[CMD_LSB +: 3]) != CMD_CHAN_RST)
      begin
        case (scc_crc_e'(b[CRC_LSB +: 2]))
          CRC_RST_RX:
          begin
            nxt_st.rxcrc[ch] = 1'b1;
            nxt_st.rxseed[ch] = sdlc ? CRC_ONES : CRC_ZEROS;
          end
          CRC_RST_TX:
          begin
            nxt_st.txcrc[ch] = 1'b1;
            nxt_st.txseed[ch] = sdlc ? CRC_ONES : CRC_ZEROS;
          end
          CRC_RST_EOM:
          begin
            nxt_st.end_of_message[ch] = 1'b0;
          end
          default: ;
        endcase
      end
    end

    if (bus.rd_stb)
    begin
      nxt_st.rvalid = 1'b1;
      if (bus.ctl_sel == SEL_DATA)
      begin
        nxt_st.rdata = rx_data_i[ch];
        nxt_st.rx_int[ch] = 1'b0;
      end
      else
      begin
        rr1 = 8'h00;
        rr1[RR1_PAR_BIT] = st_ff.par_err[ch];
        rr1[RR1_OVR_BIT] = st_ff.ovr_err[ch];
        if (st_ff.ptr[ch] == RD_PRIMARY)
        begin
          nxt_st.rdata = st_ff.ext_hold[ch] ? st_ff.rr0_snap[ch]
                                            : ext_status_i[ch];
        end
        else if (st_ff.ptr[ch] == RD_SPECIAL)
        begin
          nxt_st.rdata = rr1;
        end
        else if (st_ff.ptr[ch] == RD_VECTOR)
        begin
          nxt_st.rdata = st_ff.wreg[ch][REG_VECTOR];
        end
        else
        begin
          nxt_st.rdata = 8'h00;
        end
        nxt_st.ptr[ch] = REG_CMD;
      end
    end

    // Hardware events come last so a set in a clearing cycle wins
    for (int i = 0; i < NUM_CH; i++)
    begin
      cfg = nxt_st.wreg[i][REG_IRQ_CFG];
      if (ext_change_i[i] && !nxt_st.ext_hold[i])
      begin
        nxt_st.ext_hold[i] = 1'b1;
        nxt_st.rr0_snap[i] = ext_status_i[i];
        nxt_st.ext_int[i] = cfg[IRQ_EXT_EN_BIT];
      end
      if (parity_err_i[i])
      begin
        nxt_st.par_err[i] = 1'b1;
      end
      if (overrun_err_i[i])
      begin
        nxt_st.ovr_err[i] = 1'b1;
      end
      if (rx_char_i[i] && (cfg[IRQ_RXM_LSB +: 2] == RXM_FIRST))
      begin
        nxt_st.rx_int[i] = nxt_st.rx_int[i] | nxt_st.rx_arm[i];
        nxt_st.rx_arm[i] = 1'b0;
      end
      else if (rx_char_i[i] && (cfg[IRQ_RXM_LSB +: 2] != RXM_OFF))
      begin
        nxt_st.rx_int[i] = 1'b1;
      end
      // new character or CRC end lifts suppression
      if (tx_load_i[i] || crc_done_i[i])
      begin
        nxt_st.tx_supp[i] = 1'b0;
      end
      if (tx_empty_i[i] && cfg[IRQ_TX_EN_BIT] && !nxt_st.tx_supp[i])
      begin
        nxt_st.tx_int[i] = 1'b1;
      end
      if (underrun_i[i])
      begin
        nxt_st.end_of_message[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '0;
      st_ff.rx_arm <= '1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign wreg_o = st_ff.wreg;
  assign ext_int_o = st_ff.ext_int;
  assign rx_int_o = st_ff.rx_int;
  assign tx_int_o = st_ff.tx_int;
  assign eom_latch_o = st_ff.end_of_message;
  assign send_abort_o = st_ff.abort;
  assign chan_rst_o = st_ff.crst;
  assign rx_crc_rst_o = st_ff.rxcrc;
  assign tx_crc_rst_o = st_ff.txcrc;
  assign rx_crc_seed_o = st_ff.rxseed;
  assign tx_crc_seed_o = st_ff.txseed;
  assign prio_rst_o = st_ff.prio;
  assign return_from_interrupt_opcode_o = st_ff.return_from_interrupt_opcode;
  assign tx_data_o = st_ff.txd;
  assign tx_data_vld_o = st_ff.txv;
  assign bus.rdata = st_ff.rdata;
  assign bus.rvalid = st_ff.rvalid;

endmodule

// File: scc_host.sv
// CPU-side end: Avalon-MM command registers driving the channel bus
module scc_host
  import scc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  scc_if.host bus
);

  typedef enum logic [1:0] {
    H_IDLE,
    H_RDWAIT,
    H_GAP
  } scc_hst_e;

  typedef struct packed {
    scc_hst_e state;
    logic [2:0] gap;
    logic [1:0][2:0] ptr;
    logic [7:0] rbyte;
    logic wreq;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic chan;
    logic ctl;
    logic [7:0] wdata;
  } scc_hst_s;

  scc_hst_s st_ff;
  scc_hst_s nxt_st;

  always_comb
  begin
    logic ch;
    logic [7:0] b;
    ch = avs_writedata_i[AV_CHAN_BIT];
    b = avs_writedata_i[7:0];
    nxt_st = st_ff;
    nxt_st.wreq = 1'b1;
    nxt_st.wr = 1'b0;
    nxt_st.rd = 1'b0;

    case (st_ff.state)
      H_RDWAIT:
      begin
        if (bus.rvalid)
        begin
          nxt_st.rbyte = bus.rdata;
          nxt_st.state = H_IDLE;
        end
      end
      H_GAP:
      begin
        nxt_st.gap = st_ff.gap - GAP_LAST;
        if (st_ff.gap == GAP_LAST)
        begin
          nxt_st.state = H_IDLE;
        end
      end
      default: ;
    endcase

    // A low waitrequest answers once; the next request starts a new wait
    if (st_ff.wreq && avs_read_i)
    begin
      nxt_st.wreq = 1'b0;
      nxt_st.rdata = 32'h0000_0000;
      if (avs_address_i == AV_STAT)
      begin
        nxt_st.rdata[AV_BUSY_BIT] = (st_ff.state != H_IDLE);
        nxt_st.rdata[AV_RDATA_LSB +: 8] = st_ff.rbyte;
      end
    end
    else if (st_ff.wreq && avs_write_i && (avs_address_i != AV_CMD))
    begin
      nxt_st.wreq = 1'b0;
    end
    else if (st_ff.wreq && avs_write_i && (st_ff.state == H_IDLE))
    begin
      // Busy back-pressure: a command write stalls until idle
      nxt_st.wreq = 1'b0;
      nxt_st.chan = ch;
      nxt_st.ctl = avs_writedata_i[AV_CTL_BIT];
      nxt_st.wdata = b;
      if (avs_writedata_i[AV_READ_BIT])
      begin
        nxt_st.rd = 1'b1;
        nxt_st.state = H_RDWAIT;
        if (avs_writedata_i[AV_CTL_BIT] == SEL_CMD)
        begin
          nxt_st.ptr[ch] = REG_CMD;
        end
      end
      else
      begin
        nxt_st.wr = 1'b1;
        if ((avs_writedata_i[AV_CTL_BIT] == SEL_CMD) &&
            (st_ff.ptr[ch] != REG_CMD))
        begin
          nxt_st.ptr[ch] = REG_CMD;
        end
        else if (avs_writedata_i[AV_CTL_BIT] == SEL_CMD)
        begin
          nxt_st.ptr[ch] = b[PTR_LSB +: PTR_W];
          if (scc_cmd_e'(b[CMD_LSB +: 3]) == CMD_CHAN_RST)
          begin
            nxt_st.ptr[ch] = REG_CMD;
            nxt_st.state = H_GAP;
            nxt_st.gap = RESET_GAP_CYC;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '0;
      st_ff.wreq <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = st_ff.wreq;
  assign bus.wr_stb = st_ff.wr;
  assign bus.rd_stb = st_ff.rd;
  assign bus.chan_sel = st_ff.chan;
  assign bus.ctl_sel = st_ff.ctl;
  assign bus.wdata = st_ff.wdata;

endmodule

// File: scc_props.sv
// Interface checker for the host bus between the two decoder ends
module scc_props
  import scc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic chan_sel,
  input wire logic ctl_sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  typedef struct packed {
    logic [1:0][2:0] ptr;
    logic [1:0][7:0] vec;
    logic [1:0] vok;
  } scc_chk_s;
  scc_chk_s st_ff;
  scc_chk_s nxt_st;
  logic is_val;
  logic is_rst;
  assign is_val = ctl_sel && (st_ff.ptr[chan_sel] != REG_CMD);
  assign is_rst = wr_stb && ctl_sel && !is_val && (wdata[5:3] == 3'h3);
  // Shadow pointer follows command-port traffic only
  always_comb
  begin
    nxt_st = st_ff;
    if ((wr_stb || rd_stb) && ctl_sel)
    begin
      nxt_st.ptr[chan_sel] = REG_CMD;
      if (wr_stb && !is_val && !is_rst)
        nxt_st.ptr[chan_sel] = wdata[2:0];
      if (is_rst)
        nxt_st.vok[chan_sel] = 1'b0;
      if (wr_stb && is_val && st_ff.ptr[chan_sel] == REG_VECTOR)
      begin
        nxt_st.vec[chan_sel] = wdata;
        nxt_st.vok[chan_sel] = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_one_stb;
    !(wr_stb && rd_stb);
  endproperty
  a_one_stb: assert property (p_one_stb)
    else $error("both strobes high");
  property p_rd_answer;
    rd_stb |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered next cycle");
  property p_rv_cause;
    rvalid |-> $past(rd_stb);
  endproperty
  a_rv_cause: assert property (p_rv_cause)
    else $error("answer without read");
  property p_rd_hold;
    !rvalid |-> $stable(rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read byte moved between reads");
  property p_vec_read;
    rd_stb && ctl_sel && st_ff.ptr[chan_sel] == REG_VECTOR
      && st_ff.vok[chan_sel] |=> rdata == st_ff.vec[$past(chan_sel)];
  endproperty
  a_vec_read: assert property (p_vec_read)
    else $error("register two read wrong");
  property p_hi_read;
    rd_stb && ctl_sel && st_ff.ptr[chan_sel] > 3'h2 |=> rdata == 8'h00;
  endproperty
  a_hi_read: assert property (p_hi_read)
    else $error("unused read register not zero");
  property p_rst_gap;
    is_rst |=> !wr_stb [*4];
  endproperty
  a_rst_gap: assert property (p_rst_gap)
    else $error("write too soon after channel reset");
  property p_wr_pulse;
    wr_stb |=> !wr_stb;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than a cycle");
endmodule

// File: test_serial_channel_command_decoder.sv
// Self-checking bench joining host end and channel decoder end
module test_serial_channel_command_decoder
  import scc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_wdata = '0;
  logic [31:0] avs_rdata;
  logic avs_wait;
  logic [1:0] ext_chg = '0, tx_emp = '0, tx_ld = '0, rx_chr = '0;
  logic [1:0] par_err = '0, ovr_err = '0, und = '0, crc_dn = '0;
  logic [1:0][7:0] ext_st = '0, rx_dat = '0;
  logic [1:0][7:0][7:0] wreg;
  logic [1:0] ext_int, rx_int, tx_int, end_of_message, abort, crst, rxc, txc, txv;
  logic [1:0][15:0] rxs, txs;
  logic prio, return_from_interrupt_opcode;
  logic [7:0] txd;
  logic [7:0] last_tx = '0;
  logic [7:0] rb;
  logic [31:0] q;
  logic [6:0][1:0] pl;
  int cnt [7][2];
  int ecnt [7][2];
  int eptr [2];
  logic [7:0] ew [2][8];
  bit eok [2][8];
  int n_errors = 0;
  int samples_checked = 0;
  int seed;
  scc_if bus();
  scc_host u_scc_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
    .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait), .bus(bus));
  scc_dev u_scc_dev (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .ext_change_i(ext_chg), .ext_status_i(ext_st), .rx_char_i(rx_chr),
    .rx_data_i(rx_dat), .parity_err_i(par_err), .overrun_err_i(ovr_err),
    .tx_empty_i(tx_emp), .tx_load_i(tx_ld), .crc_done_i(crc_dn),
    .underrun_i(und), .wreg_o(wreg), .ext_int_o(ext_int), .rx_int_o(rx_int),
    .tx_int_o(tx_int), .eom_latch_o(end_of_message), .send_abort_o(abort),
    .chan_rst_o(crst), .rx_crc_rst_o(rxc), .tx_crc_rst_o(txc),
    .rx_crc_seed_o(rxs), .tx_crc_seed_o(txs), .prio_rst_o(prio),
    .return_from_interrupt_opcode_o(return_from_interrupt_opcode), .tx_data_o(txd), .tx_data_vld_o(txv));
  scc_props u_scc_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .chan_sel(bus.chan_sel),
    .ctl_sel(bus.ctl_sel), .wdata(bus.wdata), .rdata(bus.rdata),
    .rvalid(bus.rvalid));
  assign pl = {txv, 1'b0, return_from_interrupt_opcode, 1'b0, prio, txc, rxc, crst, abort};
  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // Pulse outputs are counted so that no single cycle has to be caught
  always @(posedge ref_clk_i)
  begin
    if (rst_n_i)
      for (int c = 0; c < 2; c++)
      begin
        for (int k = 0; k < 7; k++)
          if (pl[k][c] === 1'b1)
            cnt[k][c]++;
        if (txv[c] === 1'b1)
          last_tx <= txd;
      end
  end
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_wdata <= d;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (avs_wait !== 1'b0 && n < 50);
    rd = avs_rdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic model(input int c, input bit ctl, input bit rd,
                       input logic [7:0] b);
    if (ctl && rd)
      eptr[c] = 0;
    else if (ctl && eptr[c] != 0)
    begin
      ew[c][eptr[c]] = b;
      eok[c][eptr[c]] = 1'b1;
      eptr[c] = 0;
    end
    else if (ctl && b[5:3] == 3'h3)
    begin
      ecnt[1][c]++;
      if (c == 0)
        ecnt[4][0]++;
      eptr[c] = 0;
      for (int i = 0; i < 8; i++)
      begin
        eok[c][i] = 1'b0;
        ew[c][i] = 8'h00;
      end
    end
    else if (ctl)
    begin
      ew[c][0] = b;
      eok[c][0] = 1'b1;
      eptr[c] = b[2:0];
      if (b[5:3] == 3'h1 && ew[c][4][5:4] == MODE_SDLC)
        ecnt[0][c]++;
      if (b[5:3] == 3'h7 && c == 0)
        ecnt[5][0]++;
      if (b[7:6] == 2'h1)
        ecnt[2][c]++;
      if (b[7:6] == 2'h2)
        ecnt[3][c]++;
      if (b[7:6] == 2'h2)
        check("txseed", txs[c], ew[c][4][5:4] == MODE_SDLC ? CRC_ONES : 0);
      if (b[7:6] == 2'h1 && ew[c][4][5:4] == MODE_SDLC)
        check("rxseed", rxs[c], CRC_ONES);
    end
    else if (!rd)
    begin
      ecnt[6][c]++;
      check("txdata", last_tx, b);
    end
  endtask
  task automatic xfer(input int c, input bit ctl, input bit rd,
                      input logic [7:0] b, output logic [7:0] rbyte);
    logic [31:0] s;
    int n;
    n = 0;
    av(1'b1, AV_CMD, {21'h0, rd, 1'(c), ctl, b}, s);
    do
    begin
      av(1'b0, AV_STAT, '0, s);
      n++;
    end
    while (s[AV_BUSY_BIT] !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      stop_test();
    end
    rbyte = s[15:8];
    model(c, ctl, rd, b);
    for (int h = 0; h < 2; h++)
    begin
      for (int i = 0; i < 8; i++)
        if (eok[h][i])
          check("wreg", wreg[h][i], ew[h][i]);
      for (int k = 0; k < 7; k++)
        check("pulses", cnt[k][h], ecnt[k][h]);
    end
  endtask
  task automatic pulse(input int w, input int c);
    case (w)
      0: ext_chg[c] <= 1'b1;
      1: tx_emp[c] <= 1'b1;
      2: tx_ld[c] <= 1'b1;
      3: rx_chr[c] <= 1'b1;
      4: {par_err[c], ovr_err[c]} <= 2'h3;
      default: und[c] <= 1'b1;
    endcase
    @(posedge ref_clk_i);
    {ext_chg, tx_emp, tx_ld, rx_chr, par_err, ovr_err, und} <= '0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  initial
  begin
    seed = 32'h56230F09;
    repeat (5) @(posedge ref_clk_i);
    check("wait_rst", avs_wait, 1'b1);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int c = 0; c < 2; c++)
      for (int i = 0; i < 8; i++)
        check("wreg_rst", wreg[c][i], 8'h00);
    // Data bytes wedged between pointer and value must not move the pointer
    for (int c = 0; c < 2; c++)
      for (int r = 1; r < 8; r++)
      begin
        xfer(c, 1'b1, 1'b0, 8'(r), rb);
        xfer(c, 1'b0, 1'b0, 8'($random(seed)), rb);
        xfer(c, 1'b1, 1'b0, 8'($random(seed)), rb);
      end
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 2; c++)
      begin
        xfer(c, 1'b1, 1'b0, 8'h04, rb);
        xfer(c, 1'b1, 1'b0, m ? 8'h20 : 8'h00, rb);
        for (int k = 0; k < 32; k++)
          if (k[2:0] != 3)
          begin
            xfer(c, 1'b1, 1'b0, {k[4:3], k[2:0], 3'h2}, rb);
            xfer(c, 1'b1, 1'b0, 8'($random(seed)), rb);
          end
        xfer(c, 1'b1, 1'b0, 8'h02, rb);
        xfer(c, 1'b1, 1'b1, 8'h00, rb);
        check("vector", rb, ew[c][2]);
        xfer(c, 1'b1, 1'b0, 8'h03, rb);
        xfer(c, 1'b1, 1'b1, 8'h00, rb);
        check("reg3", rb, 8'h00);
        // Reset wins over the pointer loaded in the same byte
        xfer(c, 1'b1, 1'b0, 8'h1B, rb);
        xfer(c, 1'b1, 1'b0, 8'h02, rb);
        xfer(c, 1'b1, 1'b0, 8'($random(seed)), rb);
        xfer(c, 1'b1, 1'b0, 8'h04, rb);
        xfer(c, 1'b1, 1'b0, 8'h00, rb);
      end
    for (int c = 0; c < 2; c++)
    begin
      xfer(c, 1'b1, 1'b0, 8'h01, rb);
      xfer(c, 1'b1, 1'b0, 8'h0B, rb);
      pulse(0, c);
      check("ext_int", ext_int[c], 1'b1);
      xfer(c, 1'b1, 1'b0, 8'h10, rb);
      check("ext_int", ext_int[c], 1'b0);
      pulse(1, c);
      check("tx_int", tx_int[c], 1'b1);
      xfer(c, 1'b1, 1'b0, 8'h28, rb);
      pulse(1, c);
      check("tx_int", tx_int[c], 1'b0);
      pulse(2, c);
      pulse(1, c);
      check("tx_int", tx_int[c], 1'b1);
      pulse(3, c);
      check("rx_int", rx_int[c], 1'b1);
      xfer(c, 1'b0, 1'b1, 8'h00, rb);
      pulse(3, c);
      check("rx_int", rx_int[c], 1'b0);
      xfer(c, 1'b1, 1'b0, 8'h20, rb);
      pulse(3, c);
      check("rx_int", rx_int[c], 1'b1);
      pulse(4, c);
      xfer(c, 1'b1, 1'b0, 8'h01, rb);
      xfer(c, 1'b1, 1'b1, 8'h00, rb);
      check("errs", rb[5:4], 2'h3);
      xfer(c, 1'b1, 1'b0, 8'h31, rb);
      xfer(c, 1'b1, 1'b1, 8'h00, rb);
      check("errs", rb[5:4], 2'h0);
      pulse(5, c);
      check("eom", end_of_message[c], 1'b1);
      xfer(c, 1'b1, 1'b0, 8'hC0, rb);
      check("eom", end_of_message[c], 1'b0);
    end
    // Unmapped offset is answered but must change nothing
    av(1'b1, 4'hC, 32'h0000_0118, q);
    av(1'b0, AV_CMD, '0, q);
    check("cmd_read", q, 32'h0);
    xfer(0, 1'b1, 1'b0, 8'h00, rb);
    stop_test();
  end
endmodule
